/* File: bench/tb_top.sv */
// Self-checking bench for the two-wire register bank
`timescale 1ns/1ps
module tb_top;
   logic mclk_i = 1'b0, rst_n_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0, read_clear_en_i = 1'b0;
   logic data_line_out_i = 1'b0, data_line_oe_i = 1'b0, clock_line_out_i = 1'b0;
   logic clock_line_oe_i = 1'b0;
   logic [7:0] addr_i = 8'h00, data_pin_in_i = 8'hFF, clock_pin_in_i = 8'hFF;
   logic [31:0] wdata_i = 32'h0;
   logic [18:0] hw_set_i = 19'h0, hw_clr_i = 19'h0;
   wire [31:0] rdata_o;
   wire [18:0] flags_o;
   wire irq_o, data_line_in_o, clock_line_in_o;
   wire [7:0] data_pin_out_o, data_pin_oe_o, clock_pin_out_o, clock_pin_oe_o;
   int errors = 0, samples_checked = 0, cycles = 0;
   tirq_reg_bank i_dut (.*);
   always #5 mclk_i = ~mclk_i;
   always @(posedge mclk_i) begin
      cycles <= cycles + 1;
      if (cycles == 1000) begin
         errors++;
         conclude();
      end
   end
   task conclude();
      $display("errors %0d samples_checked %0d", errors, samples_checked);
      if (errors == 0 && samples_checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task cmp(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         errors++;
         $display("MISMATCH %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // Strobes stay up between calls so back-to-back calls run in consecutive cycles; idle() drops both, wr() drops rd_i, rd() drops wr_i
   task wr(input logic [7:0] a, input logic [31:0] d);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      rd_i <= 1'b0;
      @(posedge mclk_i);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      addr_i <= a;
      rd_i <= 1'b1;
      wr_i <= 1'b0;
      @(posedge mclk_i);
      fork
         #1 cmp(rdata_o, e);
      join_none
   endtask
   task idle();
      wr_i <= 1'b0;
      rd_i <= 1'b0;
      @(posedge mclk_i);
   endtask
   initial begin
      repeat (8) @(posedge mclk_i);
      rst_n_i <= 1'b1;
      rd(8'h3C, 32'h0);
      rd(8'h40, 32'h0);
      rd(8'h44, 32'h0);
      rd(8'h48, 32'h0);
      rd(8'h50, 32'h0);
      wr(8'h40, 32'h7FFFF);
      rd(8'h40, 32'h7FFFF);
      wr(8'h38, 32'h7FFCE);
      rd(8'h34, 32'h10);
      wr(8'h38, 32'h1);
      rd(8'h34, 32'h11);
      cmp({31'h0, irq_o}, 32'h1);
      wr(8'h40, 32'h0);
      rd(8'h34, 32'h11);
      cmp({31'h0, irq_o}, 32'h0);
      hw_set_i <= 19'h7FFFF;
      idle();
      hw_set_i <= 19'h0;
      wr(8'h3C, 32'h0);
      rd(8'h34, 32'h7FFFF);
      wr(8'h3C, 32'h7FFCF);
      rd(8'h34, 32'h30);
      rd(8'h3C, 32'h0);
      read_clear_en_i <= 1'b1;
      rd(8'h3C, 32'h30);
      rd(8'h40, 32'h0);
      rd(8'h34, 32'h0);
      wr(8'h48, 32'h502);
      rd(8'h48, 32'h502);
      wr(8'h44, 32'h3);
      data_line_out_i <= 1'b1;
      data_line_oe_i <= 1'b1;
      clock_line_out_i <= 1'b1;
      clock_line_oe_i <= 1'b1;
      data_pin_in_i <= 8'hFB;
      clock_pin_in_i <= 8'hDF;
      rd(8'h44, 32'h3);
      cmp({14'h0, data_pin_oe_o, clock_pin_oe_o, data_line_in_o, clock_line_in_o}, 32'h1080);
      cmp({16'h0, data_pin_out_o, clock_pin_out_o}, 32'h0420);
      wr(8'h44, 32'h0);
      rd(8'h44, 32'h0);
      cmp({14'h0, data_pin_oe_o, clock_pin_oe_o, data_line_in_o, clock_line_in_o}, 32'h3);
      idle();
      conclude();
   end
endmodule

/* File: bench/tirq_reg_bank_props.sv */
// Port checker for the two-wire register bank
`timescale 1ns/1ps
module tirq_reg_bank_props (
   input wire mclk_i,
   input wire rst_n_i,
   input wire [7:0] addr_i,
   input wire [31:0] wdata_i,
   input wire wr_i,
   input wire rd_i,
   input wire [31:0] rdata_o,
   input wire read_clear_en_i,
   input wire [18:0] hw_set_i,
   input wire [18:0] hw_clr_i,
   input wire [18:0] flags_o,
   input wire irq_o,
   input wire data_line_oe_i,
   input wire clock_line_oe_i,
   input wire [7:0] data_pin_oe_o,
   input wire [7:0] clock_pin_oe_o
);
   default clocking @(posedge mclk_i); endclocking
   default disable iff (!rst_n_i);
   // Hardware events would mask software effects
   wire quiet = hw_set_i == 19'h0 && hw_clr_i == 19'h0;
   sequence en_wr_rd;
      wr_i && addr_i == 8'h40 ##1 rd_i && addr_i == 8'h40;
   endsequence
   chk_set_start: assert property (wr_i && addr_i == 8'h38 && wdata_i[0] |=> flags_o[0])
      else $error("start flag not set");
   chk_clear_ones: assert property (wr_i && addr_i == 8'h3C && quiet |=>
      flags_o == ($past(flags_o) & ~($past(wdata_i[18:0]) & 19'h7FFCF))) else $error("bad clear");
   chk_read_clear: assert property (rd_i && addr_i == 8'h3C && read_clear_en_i && quiet |=>
      rdata_o == {13'h0, $past(flags_o)} ##[0:1] flags_o == 19'h0) else $error("bad read clear");
   chk_keep_flags: assert property (rd_i && addr_i == 8'h3C && !read_clear_en_i && quiet |=>
      $stable(flags_o)) else $error("flags lost on plain read");
   chk_enable_rw: assert property (en_wr_rd |=> rdata_o == {13'h0, $past(wdata_i[18:0], 2)})
      else $error("enable readback");
   chk_irq_cause: assert property (irq_o |-> flags_o != 19'h0)
      else $error("irq without flag");
   chk_data_route: assert property (data_pin_oe_o != 8'h00 |-> $onehot(data_pin_oe_o) && data_line_oe_i)
      else $error("data pin drive");
   chk_clock_route: assert property (clock_pin_oe_o != 8'h00 |-> $onehot(clock_pin_oe_o) && clock_line_oe_i)
      else $error("clock pin drive");
endmodule
bind tirq_reg_bank tirq_reg_bank_props i_props (.*);

/* File: inc/tirq_regs.vh */
// Register map, field layout and reset values of the two-wire register bank
`ifndef TIRQ_REGS_VH
`define TIRQ_REGS_VH

`define TIRQ_ADDR_W 8
`define TIRQ_OFF_FLAG_SET 8'h38
`define TIRQ_OFF_FLAG_CLR 8'h3C
`define TIRQ_OFF_INTR_EN 8'h40
`define TIRQ_OFF_PIN_EN 8'h44
`define TIRQ_OFF_PIN_LOC 8'h48
`define TIRQ_OFF_FLAG_RAW 8'h34

`define TIRQ_NFLAG 19
`define TIRQ_FLAG_ALL 19'h7FFFF
`define TIRQ_FLAG_CLR_MASK 19'h7FFCF
`define TIRQ_FLAG_START 0
`define TIRQ_FLAG_RESET 19'h00010
`define TIRQ_EN_RESET 19'h00000

`define TIRQ_PEN_DATA 0
`define TIRQ_PEN_CLK 1
`define TIRQ_PEN_RESET 2'h0

`define TIRQ_LOC_W 6
`define TIRQ_LOC_DATA_LSB 0
`define TIRQ_LOC_DATA_MSB 5
`define TIRQ_LOC_CLK_LSB 8
`define TIRQ_LOC_CLK_MSB 13
`define TIRQ_LOC_RESET 6'h00

`endif

/* File: src/tirq_flag_bit.v */
// One interrupt flag: hardware set, software set, clear
`timescale 1ns/1ps
module tirq_flag_bit #(
   parameter RESET_VAL = 1'b0
) (
   input wire mclk_i,
   input wire rst_n_i,
   input wire hw_set_i,
   input wire sw_set_i,
   input wire clr_i,
   output wire flag_o
);
   reg flag_q;
   reg flag_d;

   // Set wins over clear so no event is lost
   always @* begin
      flag_d = flag_q;
      if (clr_i) begin
         flag_d = 1'b0;
      end
      if (hw_set_i | sw_set_i) begin
         flag_d = 1'b1;
      end
   end

   always @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         flag_q <= RESET_VAL;
      end else begin
         flag_q <= flag_d;
      end
   end

   assign flag_o = flag_q;
endmodule

/* File: src/tirq_pin_mux.v */
// Routes one controller line to one of eight pin locations
`timescale 1ns/1ps
module tirq_pin_mux (
   input wire enable_i,
   input wire [5:0] loc_i,
   input wire line_out_i,
   input wire line_oe_i,
   input wire [7:0] pin_in_i,
   output wire [7:0] pin_out_o,
   output wire [7:0] pin_oe_o,
   output wire line_in_o
);
   genvar g;
   generate
      for (g = 0; g < 8; g = g + 1) begin : g_loc
         wire sel;
         assign sel = enable_i & (loc_i == g);
         assign pin_out_o[g] = sel & line_out_i;
         assign pin_oe_o[g] = sel & line_oe_i;
      end
   endgenerate

   // Disconnected or unused location reads as released (high) line
   assign line_in_o = (enable_i && (loc_i < 6'h08)) ? pin_in_i[loc_i[2:0]] : 1'b1;
endmodule

/* File: src/tirq_reg_bank.v */
// Flag, enable and pin routing registers of the two-wire bus controller
// ********************************************************************
// ********************************************************************
`timescale 1ns/1ps
`include "tirq_regs.vh"
module tirq_reg_bank (
   input wire mclk_i,
   input wire rst_n_i,
   input wire [7:0] addr_i,
   input wire [31:0] wdata_i,
   input wire wr_i,
   input wire rd_i,
   output wire [31:0] rdata_o,
   input wire read_clear_en_i,
   input wire [18:0] hw_set_i,
   input wire [18:0] hw_clr_i,
   output wire [18:0] flags_o,
   output wire irq_o,
   input wire data_line_out_i,
   input wire data_line_oe_i,
   input wire clock_line_out_i,
   input wire clock_line_oe_i,
   output wire data_line_in_o,
   output wire clock_line_in_o,
   input wire [7:0] data_pin_in_i,
   output wire [7:0] data_pin_out_o,
   output wire [7:0] data_pin_oe_o,
   input wire [7:0] clock_pin_in_i,
   output wire [7:0] clock_pin_out_o,
   output wire [7:0] clock_pin_oe_o
);
   // ****************************************************************
   // Decode
   // ****************************************************************
   wire wr_set;
   wire wr_clr;
   wire wr_en;
   wire wr_pen;
   wire wr_loc;
   wire rd_clr;
   assign wr_set = wr_i && (addr_i == `TIRQ_OFF_FLAG_SET);
   assign wr_clr = wr_i && (addr_i == `TIRQ_OFF_FLAG_CLR);
   assign wr_en = wr_i && (addr_i == `TIRQ_OFF_INTR_EN);
   assign wr_pen = wr_i && (addr_i == `TIRQ_OFF_PIN_EN);
   assign wr_loc = wr_i && (addr_i == `TIRQ_OFF_PIN_LOC);
   assign rd_clr = rd_i && (addr_i == `TIRQ_OFF_FLAG_CLR);

   // ****************************************************************
   // Flags
   // ****************************************************************
   wire [18:0] flag;
   wire [18:0] sw_set;
   wire [18:0] sw_clr;
   // Named copy so each flag can pick its own reset bit at the right width
   localparam [18:0] FLAG_RST = `TIRQ_FLAG_RESET;
   // Only start flag is software-settable here; rest of set register lives elsewhere
   assign sw_set = wr_set ? {18'h00000, wdata_i[`TIRQ_FLAG_START]} : 19'h00000;
   // Reserved bits of the written word are ignored
   assign sw_clr = (wr_clr ? (wdata_i[18:0] & `TIRQ_FLAG_CLR_MASK) : 19'h00000)
                 | (rd_clr && read_clear_en_i ? flag : 19'h00000)
                 | hw_clr_i;

   genvar g;
   generate
      for (g = 0; g < `TIRQ_NFLAG; g = g + 1) begin : g_flag
         tirq_flag_bit #(
            .RESET_VAL(FLAG_RST[g])
         ) u_flag (
            .mclk_i(mclk_i),
            .rst_n_i(rst_n_i),
            .hw_set_i(hw_set_i[g]),
            .sw_set_i(sw_set[g]),
            .clr_i(sw_clr[g]),
            .flag_o(flag[g])
         );
      end
   endgenerate
   assign flags_o = flag;

   // ****************************************************************
   // Enable and routing registers
   // ****************************************************************
   reg [18:0] en_q;
   reg [1:0] pen_q;
   reg [5:0] loc_data_q;
   reg [5:0] loc_clk_q;
   always @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         en_q <= `TIRQ_EN_RESET;
         pen_q <= `TIRQ_PEN_RESET;
         loc_data_q <= `TIRQ_LOC_RESET;
         loc_clk_q <= `TIRQ_LOC_RESET;
      end else begin
         if (wr_en) begin
            en_q <= wdata_i[18:0];
         end
         if (wr_pen) begin
            pen_q <= wdata_i[1:0];
         end
         if (wr_loc) begin
            loc_data_q <= wdata_i[`TIRQ_LOC_DATA_MSB:`TIRQ_LOC_DATA_LSB];
            loc_clk_q <= wdata_i[`TIRQ_LOC_CLK_MSB:`TIRQ_LOC_CLK_LSB];
         end
      end
   end

   assign irq_o = |(flag & en_q);

   // ****************************************************************
   // Read data, one cycle after the strobe
   // ****************************************************************
   reg [31:0] rdata_q;
   reg [31:0] rdata_d;
   always @* begin
      rdata_d = 32'h00000000;
      if (rd_i) begin
         case (addr_i)
            `TIRQ_OFF_FLAG_RAW: rdata_d = {13'h0000, flag};
            // Clear register reads flags only in read-clear mode; else zero
            `TIRQ_OFF_FLAG_CLR: rdata_d = read_clear_en_i ? {13'h0000, flag} : 32'h00000000;
            `TIRQ_OFF_INTR_EN: rdata_d = {13'h0000, en_q};
            `TIRQ_OFF_PIN_EN: rdata_d = {30'h00000000, pen_q};
            `TIRQ_OFF_PIN_LOC: rdata_d = {18'h00000, loc_clk_q, 2'h0, loc_data_q};
            default: rdata_d = 32'h00000000;
         endcase
      end
   end
   always @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rdata_q <= 32'h00000000;
      end else begin
         rdata_q <= rdata_d;
      end
   end
   assign rdata_o = rdata_q;

   // ****************************************************************
   // Pin routing
   // ****************************************************************
   tirq_pin_mux u_data_mux (
      .enable_i(pen_q[`TIRQ_PEN_DATA]),
      .loc_i(loc_data_q),
      .line_out_i(data_line_out_i),
      .line_oe_i(data_line_oe_i),
      .pin_in_i(data_pin_in_i),
      .pin_out_o(data_pin_out_o),
      .pin_oe_o(data_pin_oe_o),
      .line_in_o(data_line_in_o)
   );
   tirq_pin_mux u_clock_mux (
      .enable_i(pen_q[`TIRQ_PEN_CLK]),
      .loc_i(loc_clk_q),
      .line_out_i(clock_line_out_i),
      .line_oe_i(clock_line_oe_i),
      .pin_in_i(clock_pin_in_i),
      .pin_out_o(clock_pin_out_o),
      .pin_oe_o(clock_pin_oe_o),
      .line_in_o(clock_line_in_o)
   );
endmodule
